//--- hw/art16_timer.sv
// 16-bit auto-reload down-counter with prescaler, compare, capture, pwm
`timescale 1ns/10ps
`default_nettype none
module art16_timer
    import art16_pkg::*;
(
    // clock and reset
    input  wire logic               i_clk,
    input  wire logic               i_rst,
    // byte writes and control
    input  wire art16_wr_t          i_wr,
    input  wire logic               i_run_reset_ctl,
    input  wire art16_cfg_t         i_cfg,
    input  wire logic [4:0]         i_irq_enable,
    input  wire logic [4:0]         i_flag_clear,
    // event pins
    input  wire logic               i_event_input_a,
    input  wire logic               i_event_input_b,
    // status and values
    output logic [ART16_W-1:0]      o_central_count,
    output logic [ART16_W-1:0]      o_reload_capture_reg,
    output logic [ART16_W-1:0]      o_capture_value_reg,
    output logic [ART16_W-1:0]      o_compare_value_reg,
    output logic [ART16_W-1:0]      o_mask_reg,
    output logic [4:0]              o_flags,
    // output pins
    output logic                    o_pwm_pin,
    output logic                    o_overflow_pin,
    output logic                    o_irq
);
    // ****************************************************************
    // state
    // ****************************************************************
    logic [7:0]          high_hold_q;
    logic [ART16_W-1:0]  reload_q, cmp_q, mask_q, cap_q, cnt_q, cnt_d;
    logic [3:0]          psc_q;
    logic [4:0]          flags_q, flag_set;
    logic [2:0]          sync_a_q, sync_b_q;
    logic                run_q, pwm_q, ovf_pin_q, irq_q;
    art16_state_t        state_q, state_d;

    // ****************************************************************
    // decode
    // ****************************************************************
    function automatic logic edge_of(input logic [2:1] s, input logic fall);
        edge_of = fall ? (s[2] & ~s[1]) : (~s[2] & s[1]);
    endfunction

    wire         ev_a      = edge_of(sync_a_q[2:1], i_cfg.edge_a_fall);
    wire         ev_b      = edge_of(sync_b_q[2:1], i_cfg.edge_b_fall);
    wire         run_rise  = i_run_reset_ctl & ~run_q;
    wire [3:0]   psc_mask  = (i_cfg.psc_sel == ART16_PSC_4)  ? ART16_DIV4_M :
                             (i_cfg.psc_sel == ART16_PSC_16) ? ART16_DIV16_M :
                             4'h0;
    wire         tick      = i_run_reset_ctl && ((psc_q & psc_mask) == 4'h0);
    wire [15:0]  reload_v  = i_cfg.reload_en ? reload_q : ART16_ONES;
    wire         counting  = !i_cfg.reload_en || (state_q == ART16_COUNT);
    // overflow on zero to reload transition
    wire         overflow  = tick && counting && (cnt_q == ART16_ZERO);
    // restart event per selected source
    wire         restart   = i_cfg.reload_en && (
                   (i_cfg.restart_sel == ART16_RS_A)  ? ev_a :
                   (i_cfg.restart_sel == ART16_RS_B)  ? ev_b :
                   (i_cfg.restart_sel == ART16_RS_SW) ? run_rise : 1'b0);
    wire         cmp_hit   = (cnt_q & mask_q) == (cmp_q & mask_q);
    wire         zero_hit  = (cnt_q & mask_q) == ART16_ZERO;
    wire         cmp_ev    = cmp_hit && tick;
    wire         zero_ev   = zero_hit && tick;
    // capture of counter on input b, plus restart-mode capture
    wire         cap_b     = ev_b && i_run_reset_ctl &&
                             (!i_cfg.reload_en || state_q == ART16_COUNT
                              || i_cfg.restart_sel == ART16_RS_B);
    // reload register capture only without reload
    wire         cap_a     = ev_a && i_run_reset_ctl && !i_cfg.reload_en;
    wire         wr_lo     = i_wr.wr && (i_wr.target != ART16_T_HIGH);
    wire [15:0]  wr_word   = {high_hold_q, i_wr.data};

    // ****************************************************************
    // counter next value
    // ****************************************************************
    always_comb begin
        cnt_d   = cnt_q;
        state_d = state_q;
        if (!i_run_reset_ctl) begin
            cnt_d = ART16_ZERO;
            state_d = ART16_IDLE;
        end else if (restart) begin
            cnt_d   = reload_q;
            state_d = ART16_COUNT;
        end else if (overflow) begin
            cnt_d = reload_v;
        end else if (tick && counting) begin
            cnt_d = cnt_q - 16'h0001;
        end
    end

    always_comb begin
        flag_set               = ART16_F_NONE;
        flag_set[ART16_F_A]    = ev_a && i_run_reset_ctl;
        flag_set[ART16_F_B]    = ev_b && i_run_reset_ctl;
        flag_set[ART16_F_OVF]  = overflow;
        flag_set[ART16_F_CMP]  = cmp_ev;
        flag_set[ART16_F_ZERO] = zero_ev;
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    // input synchronisers, third stage only for edge detect
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            sync_a_q <= 3'h0;
            sync_b_q <= 3'h0;
        end else begin
            sync_a_q <= {sync_a_q[1:0], i_event_input_a};
            sync_b_q <= {sync_b_q[1:0], i_event_input_b};
        end
    end

    // held until the next high write
    always_ff @(posedge i_clk) begin
        if (i_rst)
            high_hold_q <= ART16_BYTE0;
        else if (i_wr.wr && i_wr.target == ART16_T_HIGH)
            high_hold_q <= i_wr.data;
    end

    // word transfer on low write; capture into reload reg
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            reload_q <= ART16_ZERO;
            cmp_q    <= ART16_ZERO;
            mask_q   <= ART16_ONES;
        end else begin
            if (cap_a)
                reload_q <= cnt_q;
            else if (wr_lo && i_wr.target == ART16_T_RLD)
                reload_q <= wr_word;
            if (wr_lo && i_wr.target == ART16_T_CMP)
                cmp_q <= wr_word;
            if (wr_lo && i_wr.target == ART16_T_MASK)
                mask_q <= wr_word;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst)
            cap_q <= ART16_ZERO;
        else if (cap_b)
            cap_q <= cnt_q;
    end

    // counter, prescaler, sequencer
    // settings untouched, so restart reuses the mode
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cnt_q   <= ART16_ZERO;
            psc_q   <= 4'h0;
            run_q   <= 1'b0;
            state_q <= ART16_IDLE;
        end else begin
            cnt_q   <= cnt_d;
            psc_q   <= i_run_reset_ctl ? psc_q + 4'h1 : 4'h0;
            run_q   <= i_run_reset_ctl;
            state_q <= state_d;
        end
    end

    // sticky flags, a set beats a same-cycle clear
    always_ff @(posedge i_clk) begin
        if (i_rst)
            flags_q <= ART16_F_NONE;
        else
            flags_q <= (flags_q & ~i_flag_clear) | flag_set;
    end

    always_ff @(posedge i_clk) begin
        if (i_rst)
            pwm_q <= 1'b0;
        else if (!i_cfg.pwm_out_enable)
            pwm_q <= i_cfg.pwm_polarity;
        else if (i_cfg.pwm_toggle_select) begin
            if (cmp_ev)
                pwm_q <= ~pwm_q;
        end else if (cmp_ev)
            pwm_q <= i_cfg.pwm_polarity;
        else if (zero_ev)
            pwm_q <= ~i_cfg.pwm_polarity;
    end

    // overflow pin; set mode follows the sticky flag
    always_ff @(posedge i_clk) begin
        if (i_rst)
            ovf_pin_q <= 1'b0;
        else if (i_cfg.overflow_toggle_select) begin
            if (overflow)
                ovf_pin_q <= ~ovf_pin_q;
        end else
            ovf_pin_q <= (flags_q[ART16_F_OVF] & ~i_flag_clear[ART16_F_OVF])
                         | overflow;
    end

    // interrupt, registered from next flag state
    always_ff @(posedge i_clk) begin
        if (i_rst)
            irq_q <= 1'b0;
        else
            irq_q <= |(((flags_q & ~i_flag_clear) | flag_set) & i_irq_enable);
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign o_central_count      = cnt_q;
    assign o_reload_capture_reg = reload_q;
    assign o_capture_value_reg  = cap_q;
    assign o_compare_value_reg  = cmp_q;
    assign o_mask_reg           = mask_q;
    assign o_flags              = flags_q;
    assign o_pwm_pin            = pwm_q;
    assign o_overflow_pin       = ovf_pin_q;
    assign o_irq                = irq_q;
endmodule
`default_nettype wire

//--- hw/art16_pkg.sv
// shared constants and types for the 16-bit auto-reload timer
package art16_pkg;
    // ****************************************************************
    // widths and reset values
    // ****************************************************************
    localparam int          ART16_W       = 16;
    localparam logic [15:0] ART16_ONES    = 16'hFFFF;
    localparam logic [15:0] ART16_ZERO    = 16'h0000;
    localparam logic [7:0]  ART16_BYTE0   = 8'h00;
    // prescaler ratio codes
    localparam logic [1:0]  ART16_PSC_1   = 2'h0;
    localparam logic [1:0]  ART16_PSC_4   = 2'h1;
    localparam logic [1:0]  ART16_PSC_16  = 2'h2;
    localparam logic [3:0]  ART16_DIV4_M  = 4'h3;
    localparam logic [3:0]  ART16_DIV16_M = 4'hF;
    // restart source codes {restart_select_hi, restart_select_lo}
    localparam logic [1:0]  ART16_RS_SW   = 2'h0;
    localparam logic [1:0]  ART16_RS_A    = 2'h1;
    localparam logic [1:0]  ART16_RS_B    = 2'h2;
    // targets of a byte write: three 16-bit registers and the high byte hold
    localparam logic [2:0]  ART16_T_RLD   = 3'h0;
    localparam logic [2:0]  ART16_T_CMP   = 3'h1;
    localparam logic [2:0]  ART16_T_MASK  = 3'h2;
    localparam logic [2:0]  ART16_T_HIGH  = 3'h4;
    // flag bit positions
    localparam int          ART16_F_A     = 0;
    localparam int          ART16_F_B     = 1;
    localparam int          ART16_F_OVF   = 2;
    localparam int          ART16_F_CMP   = 3;
    localparam int          ART16_F_ZERO  = 4;
    localparam logic [4:0]  ART16_F_NONE  = 5'h00;

    // byte write request from the core
    typedef struct packed {
        logic       wr;
        logic [2:0] target;
        logic [7:0] data;
    } art16_wr_t;

    // mode configuration bits
    typedef struct packed {
        logic       reload_en;
        logic [1:0] restart_sel;
        logic [1:0] psc_sel;
        logic       edge_a_fall;
        logic       edge_b_fall;
        logic       pwm_out_enable;
        logic       pwm_toggle_select;
        logic       pwm_polarity;
        logic       overflow_toggle_select;
    } art16_cfg_t;

    // restart sequencer state
    typedef enum logic [1:0] {
        ART16_IDLE  = 2'b01,
        ART16_COUNT = 2'b10
    } art16_state_t;
endpackage

//--- bench/art16_ev_model.sv
// event source model driving both capture pins
`timescale 1ns/10ps
`default_nettype none
module art16_ev_model (
    // request and clock
    input  wire logic       i_clk,
    input  wire logic [1:0] i_fire,
    // event pins, idle low
    output logic      [1:0] o_pin
);
    initial o_pin = 2'h0;
    // pulse held 4 cycles so the 2-ff sync cannot miss it
    always @(posedge i_clk) begin
        for (int k = 0; k < 2; k++) begin
            if (i_fire[k]) begin
                o_pin[k] <= #1 1'b1;
                o_pin[k] <= #33 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

//--- bench/art16_timer_sva.sv
// port checker for the auto-reload timer
`timescale 1ns/10ps
`default_nettype none
module art16_timer_sva
    import art16_pkg::*;
(
    // clock, reset, controls
    input wire logic        i_clk,
    input wire logic        i_rst,
    input wire art16_wr_t   i_wr,
    input wire logic        i_run_reset_ctl,
    input wire art16_cfg_t  i_cfg,
    input wire logic [4:0]  i_irq_enable,
    input wire logic [4:0]  i_flag_clear,
    // watched outputs
    input wire logic [15:0] o_central_count,
    input wire logic [15:0] o_reload_capture_reg,
    input wire logic [15:0] o_compare_value_reg,
    input wire logic [15:0] o_mask_reg,
    input wire logic [4:0]  o_flags,
    input wire logic        o_pwm_pin,
    input wire logic        o_irq
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // free running at full rate
    wire logic free1 = i_run_reset_ctl && !i_cfg.reload_en
                       && i_cfg.psc_sel == ART16_PSC_1;
    // five cycles of quarter-rate free running
    sequence s_q4;
        (i_run_reset_ctl && !i_cfg.reload_en
         && i_cfg.psc_sel == ART16_PSC_4) [*5];
    endsequence
    chk_stop_clear: assert property (
        !i_run_reset_ctl |=> o_central_count == ART16_ZERO)
        else $error("count not clear while stopped");
    chk_regs_kept: assert property (
        !i_run_reset_ctl && !i_wr.wr |=> $stable(o_reload_capture_reg)
        && $stable(o_compare_value_reg) && $stable(o_mask_reg))
        else $error("register moved while stopped");
    chk_psc_quarter: assert property (
        s_q4 ##0 $changed(o_central_count)
        |-> $past(o_central_count, 4) == o_central_count + 16'h0001)
        else $error("quarter rate step wrong");
    chk_wrap_ones: assert property (
        free1 && o_central_count == ART16_ZERO
        |=> o_central_count == ART16_ONES)
        else $error("no wrap to all ones");
    chk_ovf_flag: assert property (
        free1 && o_central_count == ART16_ZERO |=> o_flags[ART16_F_OVF])
        else $error("overflow flag not set");
    chk_flag_sticky: assert property (
        1'b1 |=> ($past(o_flags) & ~$past(i_flag_clear) & ~o_flags)
        == ART16_F_NONE)
        else $error("flag dropped without clear");
    chk_irq_or: assert property (
        (|(o_flags & i_irq_enable) && $stable(i_irq_enable)) [*2]
        |-> o_irq)
        else $error("irq low with enabled flag");
    chk_pwm_idle: assert property (
        (!i_cfg.pwm_out_enable && $stable(i_cfg.pwm_polarity)) [*2]
        |-> o_pwm_pin == i_cfg.pwm_polarity)
        else $error("idle pwm level wrong");
endmodule
bind art16_timer art16_timer_sva u_sva (.*);
`default_nettype wire

//--- bench/art16_timer_tb.sv
// self-checking bench for the auto-reload timer
`timescale 1ns/10ps
`default_nettype none
module art16_timer_tb
    import art16_pkg::*;
;
    logic        clk, rst, run, pwm, ovf, irq, p0, o0;
    art16_wr_t   wr;
    art16_cfg_t  cfg;
    logic [4:0]  ien, fclr, flg;
    logic [1:0]  fire, pin;
    logic [15:0] cnt, rcr, cpv, cmpv, msk, c, rl, wv[3];
    int          bad_count, n_compared, n;
    // 8 ns clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    art16_timer dut (.i_clk(clk), .i_rst(rst), .i_wr(wr),
        .i_run_reset_ctl(run), .i_cfg(cfg), .i_irq_enable(ien),
        .i_flag_clear(fclr), .i_event_input_a(pin[0]),
        .i_event_input_b(pin[1]), .o_central_count(cnt),
        .o_reload_capture_reg(rcr), .o_capture_value_reg(cpv),
        .o_compare_value_reg(cmpv), .o_mask_reg(msk), .o_flags(flg),
        .o_pwm_pin(pwm), .o_overflow_pin(ovf), .o_irq(irq));
    art16_ev_model u_ev (.i_clk(clk), .i_fire(fire), .o_pin(pin));
    // drive 1 ns after the edge so sampling never races
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // high byte then low byte, strobe held between them
    task automatic w16(input logic [2:0] t, input logic [15:0] v,
                       input logic hi);
        if (hi) begin
            wr = '{1'b1, ART16_T_HIGH, v[15:8]};
            cyc(1);
        end
        wr = '{1'b1, t, v[7:0]};
        cyc(1);
        wr.wr = 1'b0;
        cyc(1);
    endtask
    // bounded wait for a zero count, n holds the cycles
    task automatic wz();
        n = 0;
        do begin
            cyc(1);
            n++;
        end while (cnt !== ART16_ZERO && n < 3000);
    endtask
    task automatic ev(input logic [1:0] f);
        fire = f;
        cyc(1);
        fire = 2'h0;
        cyc(8);
    endtask
    // count expected after k cycles at ratio code p
    function automatic logic [15:0] after(logic [15:0] s, int k, int p);
        return s - 16'(k >> (2 * p));
    endfunction
    task automatic stop_test();
        $display("compared %0d mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // watchdog, far beyond the expected run
    initial begin
        #400000;
        bad_count++;
        stop_test();
    end
    // main sequence
    initial begin
        void'($urandom(20699));
        rst = 1'b1;
        run = 1'b0;
        wr = '0;
        cfg = '0;
        ien = 5'h00;
        fclr = 5'h00;
        fire = 2'h0;
        bad_count = 0;
        n_compared = 0;
        cyc(2);
        rst = 1'b0;
        cyc(1);
        check(msk, ART16_ONES);
        check(cnt, ART16_ZERO);
        for (int k = 0; k < 3; k++) begin
            wv[k] = 16'($urandom);
            w16(3'(k), wv[k], 1'b1);
        end
        check(rcr, wv[0]);
        check(cmpv, wv[1]);
        check(msk, wv[2]);
        wv[1] = {wv[2][15:8], 8'h5A};
        w16(ART16_T_CMP, wv[1], 1'b0);
        check(cmpv, wv[1]);
        w16(ART16_T_MASK, ART16_ONES, 1'b1);
        $display("writes test done");
        for (int p = 0; p < 3; p++) begin
            cfg.psc_sel = 2'(p);
            run = 1'b1;
            cyc(20);
            c = cnt;
            cyc(32);
            check(cnt, after(c, 32, p));
            run = 1'b0;
            cyc(2);
            check(cnt, ART16_ZERO);
        end
        check(rcr, wv[0]);
        check(cmpv, wv[1]);
        check(16'(flg[2]), 16'h1);
        check(16'(ovf), 16'h1);
        fclr = 5'h04;
        cyc(1);
        fclr = 5'h00;
        cyc(1);
        check(16'(flg[2]), 16'h0);
        check(16'(ovf), 16'h0);
        $display("prescaler test done");
        rl = 16'(16 + $urandom_range(40));
        w16(ART16_T_RLD, rl, 1'b1);
        w16(ART16_T_CMP, rl >> 1, 1'b1);
        // reload mode, restart on input a, full rate, pwm output idle
        cfg = '0;
        cfg.reload_en = 1'b1;
        cfg.restart_sel = ART16_RS_A;
        cfg.psc_sel = ART16_PSC_1;
        run = 1'b1;
        cyc(4);
        check(cnt, ART16_ZERO);
        ev(2'h1);
        check(16'(cnt <= rl && cnt > rl - 16'h9), 16'h1);
        wz();
        wz();
        check(16'(n), rl + 16'h1);
        // capture lands three sync edges after the zero-edge reload
        ev(2'h2);
        check(16'(cpv <= rl && flg[1]), 16'h1);
        check(cpv, rl - 16'h2);
        check(rcr, rl);
        // clear compare and zero flags so a new period must set them
        fclr = 5'h18;
        cyc(1);
        fclr = 5'h00;
        wz();
        ien = 5'h08;
        wz();
        cyc(2);
        check(16'(flg[4:3]), 16'h3);
        check(16'(irq), 16'h1);
        run = 1'b0;
        cyc(3);
        run = 1'b1;
        ev(2'h1);
        wz();
        wz();
        check(16'(n), rl + 16'h1);
        $display("reload test done");
        for (int q = 0; q < 4; q++) begin
            cfg.pwm_polarity = q[0];
            cfg.pwm_out_enable = q[1];
            wz();
            cyc(3);
            check(16'(pwm), 16'(q[0] ^ q[1]));
        end
        cfg.pwm_toggle_select = 1'b1;
        cfg.overflow_toggle_select = 1'b1;
        wz();
        cyc(3);
        p0 = pwm;
        o0 = ovf;
        wz();
        cyc(3);
        check(16'(pwm), 16'(!p0));
        check(16'(ovf), 16'(!o0));
        $display("output test done");
        stop_test();
    end
endmodule
`default_nettype wire
